// >>> rtl/ptph_host.sv
// How it works
// - code bits sent with start command select holes punched
// - host drives activate and code bits straight from register flops
// - on initiate-termination host clamps code lines low; activate stays high until the end reset
// - second termination resets host activate flag for next char
`timescale 1ns/1ps
`default_nettype none
module ptph_host
	import ptph_pkg::*;
#(
	parameter int unsigned WIDTH = ptph_pkg::CODE_W
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             char_valid,
	input  wire logic [WIDTH-1:0] char_code,
	output var  logic             char_ready,
	input  wire logic             initiate_termination,
	input  wire logic             cycle_end_termination,
	input  wire logic             sprocket_timing_contacts,
	output var  logic             activate_punch_flag,
	output var  logic [WIDTH-1:0] output_code_bits,
	output var  logic             activate_reset_pulse,
	output var  logic             char_done,
	output var  logic             sprocket_seen
);
	import ptph_pkg::*;

	ptph_evt_if evt ();

	ptph_edge u_edge (
		.sys_clk                  (sys_clk),
		.rst                      (rst),
		.initiate_termination     (initiate_termination),
		.cycle_end_termination    (cycle_end_termination),
		.sprocket_timing_contacts (sprocket_timing_contacts),
		.evt                      (evt)
	);

	// any state but idle owns the punch drivers
	// used by ready, code clear and sprocket status
	function automatic logic cycle_busy(input ptph_state_t st);
		cycle_busy = (st != PTPH_IDLE);
	endfunction

	// registers and their next values
	ptph_state_t      state_ff;
	ptph_state_t      nxt_state;
	logic             flag_ff;
	logic             nxt_flag;
	logic [WIDTH-1:0] code_ff;
	logic [WIDTH-1:0] nxt_code;
	logic             ready_ff;
	logic             nxt_ready;
	logic             rpulse_ff;
	logic             nxt_rpulse;
	logic             done_ff;
	logic             nxt_done;
	logic             spr_ff;
	logic             nxt_spr;
	logic             take_now;
	logic             start_seen;
	logic             end_seen;
	logic             closing;

	// termination edges count only in the state that expects them
	assign take_now   = (state_ff == PTPH_IDLE) && ready_ff && char_valid;
	assign start_seen = (state_ff == PTPH_DRIVE) && evt.init_term_rise;
	assign end_seen   = (state_ff == PTPH_CLAMP) && evt.end_term_rise;
	// flag reset and done fall in the closing state
	assign closing    = (state_ff == PTPH_WAIT_RESET);

	// sequencer: take, cycle start, end of revolution, flag reset
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			PTPH_IDLE: begin
				if (take_now) begin
					nxt_state = PTPH_DRIVE;
				end
			end
			PTPH_DRIVE: begin
				// wait for clutch contacts, cycle start
				if (start_seen) begin
					nxt_state = PTPH_CLAMP;
				end
			end
			PTPH_CLAMP: begin
				// camshaft keeps turning on its own
				if (end_seen) begin
					nxt_state = PTPH_WAIT_RESET;
				end
			end
			PTPH_WAIT_RESET: begin
				nxt_state = PTPH_IDLE;
			end
			default: begin
				nxt_state = PTPH_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_ff <= PTPH_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// activate flag: set on take, zero-set only by the end reset
	// clutch line stays up through the clamp; the punch
	// releases its contacts once the flag drops
	always_comb begin
		nxt_flag = flag_ff;
		if (take_now) begin
			nxt_flag = 1'b1;
		end else if (closing) begin
			nxt_flag = FLAG_RST;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			flag_ff <= FLAG_RST;
		end else begin
			flag_ff <= nxt_flag;
		end
	end

	// code lines: loaded on take, clamped on cycle start
	// and held clear while idle
	always_comb begin
		nxt_code = code_ff;
		if (take_now) begin
			nxt_code = char_code;
		end else if (start_seen || !cycle_busy(state_ff)) begin
			nxt_code = WIDTH'(CODE_RST);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			code_ff <= WIDTH'(CODE_RST);
		end else begin
			code_ff <= nxt_code;
		end
	end

	// ready only from the second idle cycle on, so a request
	// still held from the last take is not taken twice
	always_comb begin
		nxt_ready = 1'b0;
		if (!cycle_busy(state_ff) && !take_now) begin
			nxt_ready = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ready_ff <= 1'b0;
		end else begin
			ready_ff <= nxt_ready;
		end
	end

	// one-cycle reset pulse, then one-cycle done
	// the pulse shows one cycle before the flag drops
	always_comb begin
		nxt_rpulse = end_seen;
		nxt_done   = closing;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rpulse_ff <= 1'b0;
			done_ff   <= 1'b0;
		end else begin
			rpulse_ff <= nxt_rpulse;
			done_ff   <= nxt_done;
		end
	end

	// sprocket status, cleared by each new take
	always_comb begin
		nxt_spr = spr_ff;
		if (take_now) begin
			nxt_spr = 1'b0;
		end else if (evt.sprocket_rise && cycle_busy(state_ff)) begin
			nxt_spr = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			spr_ff <= 1'b0;
		end else begin
			spr_ff <= nxt_spr;
		end
	end

	// clamp: code lines carry data only while flag drives them
	assign activate_punch_flag  = flag_ff;
	assign output_code_bits     = code_ff;
	assign char_ready           = ready_ff;
	assign activate_reset_pulse = rpulse_ff;
	assign char_done            = done_ff;
	assign sprocket_seen        = spr_ff;
endmodule
`default_nettype wire

// >>> rtl/ptph_pkg.sv
package ptph_pkg;
	localparam int unsigned CODE_W      = 5;
	localparam logic [4:0]  CODE_RST    = 5'h00;
	localparam logic        FLAG_RST    = 1'b0;
	typedef enum logic [2:0] {
		PTPH_IDLE,
		PTPH_DRIVE,
		PTPH_CLAMP,
		PTPH_WAIT_RESET
	} ptph_state_t;
endpackage

// >>> rtl/ptph_evt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ptph_evt_if;
	logic init_term_rise;
	logic end_term_rise;
	logic sprocket_rise;
	modport src (output init_term_rise, output end_term_rise,
		output sprocket_rise);
	modport dst (input init_term_rise, input end_term_rise,
		input sprocket_rise);
endinterface
`default_nettype wire

// >>> rtl/ptph_edge.sv
`timescale 1ns/1ps
`default_nettype none
module ptph_edge
	import ptph_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic initiate_termination,
	input  wire logic cycle_end_termination,
	input  wire logic sprocket_timing_contacts,
	ptph_evt_if.src   evt
);
	logic [2:0] prev_ff;
	logic [2:0] nxt_prev;
	logic [2:0] now_v;

	always_comb begin
		now_v    = {sprocket_timing_contacts, cycle_end_termination,
			initiate_termination};
		nxt_prev = now_v;
		evt.init_term_rise = now_v[0] & ~prev_ff[0];
		evt.end_term_rise  = now_v[1] & ~prev_ff[1];
		evt.sprocket_rise  = now_v[2] & ~prev_ff[2];
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			prev_ff <= 3'h0;
		end else begin
			prev_ff <= nxt_prev;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/unused_none.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> tb/ptph_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ptph_assertions (
	input wire logic       sys_clk,
	input wire logic       rst,
	input wire logic       char_valid,
	input wire logic [4:0] char_code,
	input wire logic       char_ready,
	input wire logic       initiate_termination,
	input wire logic       cycle_end_termination,
	input wire logic       activate_punch_flag,
	input wire logic [4:0] output_code_bits,
	input wire logic       activate_reset_pulse,
	input wire logic       char_done
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	take_drives_a: assert property (char_valid && char_ready |=>
		activate_punch_flag && output_code_bits == $past(char_code))
		else $error("take");
	flag_holds_a: assert property (activate_punch_flag
		&& !activate_reset_pulse |=> activate_punch_flag) else $error("hold");
	code_clamp_a: assert property ($rose(initiate_termination)
		&& activate_punch_flag |-> ##[1:2] output_code_bits == 5'h00)
		else $error("clamp");
	end_pulse_a: assert property ($rose(cycle_end_termination)
		&& activate_punch_flag |-> ##[1:2] activate_reset_pulse)
		else $error("pulse");
	flag_reset_a: assert property (activate_reset_pulse |=>
		!activate_punch_flag && char_done) else $error("reset");
	no_retake_a: assert property (activate_punch_flag |->
		!char_ready) else $error("retake");
endmodule
bind ptph_host ptph_assertions chk (
	.sys_clk               (sys_clk),
	.rst                   (rst),
	.char_valid            (char_valid),
	.char_code             (char_code),
	.char_ready            (char_ready),
	.initiate_termination  (initiate_termination),
	.cycle_end_termination (cycle_end_termination),
	.activate_punch_flag   (activate_punch_flag),
	.output_code_bits      (output_code_bits),
	.activate_reset_pulse  (activate_reset_pulse),
	.char_done             (char_done)
);
`default_nettype wire

// >>> tb/ptph_punch_model.sv
`timescale 1ns/1ps
`default_nettype none
module ptph_punch_model (
	input  wire logic       sys_clk,
	input  wire logic [3:0] dly,
	input  wire logic       tape_fault,
	input  wire logic       activate_punch_flag,
	input  wire logic [4:0] output_code_bits,
	output var  logic       initiate_termination,
	output var  logic       cycle_end_termination,
	output var  logic       sprocket_timing_contacts,
	output var  logic [4:0] holes
);
	initial begin
		{initiate_termination, cycle_end_termination} = 2'h0;
		sprocket_timing_contacts = 1'b0;
		holes = 5'h00;
		forever begin
			// open fault contacts keep the clutch from engaging
			@(posedge sys_clk iff activate_punch_flag && !tape_fault);
			repeat (dly) @(posedge sys_clk);
			holes <= output_code_bits;
			initiate_termination <= 1'b1;
			repeat (dly) @(posedge sys_clk);
			sprocket_timing_contacts <= 1'b1;
			repeat (dly) @(posedge sys_clk);
			cycle_end_termination <= 1'b1;
			@(posedge sys_clk iff !activate_punch_flag);
			{initiate_termination, cycle_end_termination} <= 2'h0;
			sprocket_timing_contacts <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> tb/ptph_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ptph_tb_top;
	import ptph_pkg::*;
	logic sys_clk, rst, char_valid, char_ready, activate_punch_flag;
	logic initiate_termination, cycle_end_termination, char_done;
	logic sprocket_timing_contacts, activate_reset_pulse, sprocket_seen;
	logic [4:0] char_code, output_code_bits, holes, c, exp_c;
	logic [3:0] dly;
	logic       tape_fault;
	int         n_fail, n_tests, seed;
	logic [4:0] q[$];
	ptph_host dut (
		.sys_clk                  (sys_clk),
		.rst                      (rst),
		.char_valid               (char_valid),
		.char_code                (char_code),
		.char_ready               (char_ready),
		.initiate_termination     (initiate_termination),
		.cycle_end_termination    (cycle_end_termination),
		.sprocket_timing_contacts (sprocket_timing_contacts),
		.activate_punch_flag      (activate_punch_flag),
		.output_code_bits         (output_code_bits),
		.activate_reset_pulse     (activate_reset_pulse),
		.char_done                (char_done),
		.sprocket_seen            (sprocket_seen)
	);
	ptph_punch_model model (
		.sys_clk                  (sys_clk),
		.dly                      (dly),
		.tape_fault               (tape_fault),
		.activate_punch_flag      (activate_punch_flag),
		.output_code_bits         (output_code_bits),
		.initiate_termination     (initiate_termination),
		.cycle_end_termination    (cycle_end_termination),
		.sprocket_timing_contacts (sprocket_timing_contacts),
		.holes                    (holes)
	);
	task final_report;
		$display("fails %0d checks %0d", n_fail, n_tests);
		if (n_fail == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input string nm, input logic [4:0] x, input logic [4:0] s);
		n_tests++;
		if (x !== s) begin
			n_fail++;
			$display("BAD %s exp %h got %h", nm, x, s);
		end
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		#300000;
		n_fail++;
		final_report();
	end
	always @(posedge sys_clk) if (char_done === 1'b1) begin
		exp_c = q.pop_front();
		chk("holes", exp_c, holes);
		chk("sprocket", 5'h01, {4'h0, sprocket_seen});
	end
	initial begin
		seed = 74563;
		{rst, char_valid, char_code, dly} = {1'b1, 1'b0, 5'h00, 4'h1};
		tape_fault = 1'b0;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			@(posedge sys_clk);
			c = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'($random(seed));
			q.push_back(c);
			dly <= (i % 3 == 0) ? 4'h6 : 4'h1;
			char_code <= c;
			char_valid <= 1'b1;
			@(posedge sys_clk iff char_ready === 1'b1);
			char_valid <= 1'b0;
			if (i == 5) begin
				// tape out before the cycle starts: punch must stall
				tape_fault <= 1'b1;
				repeat (30) @(posedge sys_clk);
				chk("stall flag", 5'h01, {4'h0, activate_punch_flag});
				chk("stall code", c, output_code_bits);
				tape_fault <= 1'b0;
			end
		end
		repeat (40) @(posedge sys_clk);
		chk("left", 5'h00, 5'(q.size()));
		final_report();
	end
endmodule
`default_nettype wire
